//--- common/rdc_cfg.svh
/*
  Constants of the relay distributor controller: register offsets, field
  positions, reset values and default timing counts.
  Assumes inclusion by bare name from package and design files.
*/
`ifndef RDC_CFG_SVH
`define RDC_CFG_SVH

// Register offsets on the bus (byte addresses)
`define RDC_ADR_CTRL 4'h0
`define RDC_ADR_STAT 4'h4
`define RDC_ADR_ORDER 4'h8
`define RDC_ADR_FAULT 4'hC

// Control register bits
`define RDC_CTRL_SYSRST 0
`define RDC_CTRL_DIAG 1
`define RDC_CTRL_INSVC 2

// Status register bits
`define RDC_STAT_BUSY 0
`define RDC_STAT_FAIL 1
`define RDC_STAT_QUAR 2
`define RDC_STAT_DONE 3
`define RDC_STAT_VERIFY 4

// Fault code bits
`define RDC_F_ADDR 0
`define RDC_F_PATH 1
`define RDC_F_MULTI 2
`define RDC_F_NONE 3
`define RDC_F_STAGE1 4
`define RDC_F_NOMOVE 5
`define RDC_F_DBLREL 6

// Order field positions, lsb of each field
`define RDC_POS_FIRST 0
`define RDC_POS_SECOND 8
`define RDC_POS_FOURTH 16
`define RDC_POS_THIRD 20
`define RDC_POS_OPREL 22
`define RDC_POS_HALF 24
`define RDC_POS_CTYPE 26

// Both bits of the cycle type field set
`define RDC_CTYPE_DIAG 2'h3

// Default cycle counts at 40 MHz
`define RDC_WIN_CYC 88
`define RDC_STROBE_CYC 40
`define RDC_HOLD_CYC 80
`define RDC_MOVE_TMO 400

`define RDC_ZERO28 28'h0000000
`define RDC_ZERO7 7'h00
`define RDC_ZERO32 32'h00000000

`endif

//--- common/rdc_pkg.sv
/*
  Types of the relay distributor controller.
  Assumes rdc_cfg.svh is on the include path.
*/
`include "rdc_cfg.svh"
package rdc_pkg;

  // Address order split into its one-hot fields
  typedef struct packed {
    logic [1:0] cycle_type_select;
    logic [1:0] selector_half_select;
    logic [1:0] operate_release_select;
    logic [1:0] path_group_third;
    logic [3:0] path_group_fourth;
    logic [7:0] path_group_second;
    logic [7:0] path_group_first;
  } rdc_order_s;

  // Feedback from the selector and relay detectors
  typedef struct packed {
    logic path_one;
    logic relay_multi;
    logic relay_none;
    logic stage1_err;
    logic armature_move;
    logic double_release;
  } rdc_sense_s;

  typedef enum logic [2:0] {
    RDC_IDLE = 3'b000,
    RDC_WINDOW = 3'b001,
    RDC_CHECK = 3'b010,
    RDC_DRIVE = 3'b011,
    RDC_HOLD = 3'b100,
    RDC_FAIL = 3'b101
  } rdc_state_e;

endpackage

//--- verilog/rdc_top.sv
/*
  Relay distributor controller: takes an enable and a one-hot address order
  from one of two buses, checks it, drives a path and the relay pulser, and
  confirms armature movement before clearing itself. Wishbone classic slave.
  Assumes sense inputs and bus pins are asynchronous and are filtered here;
  the processor sends one-hot orders and resets the controller after faults.
*/
// Functional notes
// - Enable pulse opens the address window and starts a cycle.
// - Closing the window returns an enable-verify signal to the processor.
// - Address is captured only from the bus the processor selected.
// - Address buffer is 28 bits in seven fields, held all cycle.
// - An order is valid only when every field has exactly one bit.
// - Fields choose path, operate or release, selector half, cycle type.
// - With diagnostic option, both cycle type bits form a diagnostic order.
// - Any field not one-hot halts the cycle and reports a fault.
// - Exactly one route through the selector, else stop and report.
// - Two or more relays on the output stops cycle with fault.
// - With diagnostic option, no relay found stops cycle with fault.
// - With diagnostic option, first selection stage errors are checked.
// - Armature movement marks success and clears the address buffer.
// - No movement is a fault reported with the following cycle; the code flags it at once, and the system reset clears it first.
// - Release of a released relay ends the cycle early.
// - Movement detector is ignored until a settling interval elapses.
// - End reset needs movement and selection drive held for set time.
// - After reset, enable and address are cleared, ready for next order.
// - After failure no end reset; processor system reset clears it.
// - Power-on clears registers and starts quarantined, out of service.
`timescale 1ns/100ps
`include "rdc_cfg.svh"
module rdc_top #(
  parameter int WIN_CYC = `RDC_WIN_CYC,
  parameter int STROBE_CYC = `RDC_STROBE_CYC,
  parameter int HOLD_CYC = `RDC_HOLD_CYC,
  parameter int MOVE_TMO = `RDC_MOVE_TMO,
  parameter bit DIAG_FITTED = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] enable_i,
  input wire logic [27:0] bus0_addr_i,
  input wire logic [27:0] bus1_addr_i,
  input wire logic [5:0] sense_i,
  output logic enable_verify_o,
  output logic [27:0] select_o,
  output logic operate_o,
  output logic release_o,
  output logic fault_o,
  output logic quarantine_o
);

  localparam int CW = 10;

  // Three-stage pin filters for enables, sense and address lines
  // All of these come from another domain, so the first stage may go
  // metastable; only later stages are ever looked at
  logic [1:0] en_s1, en_s2, en_s3, en_q;
  logic [5:0] sn_s1, sn_s2, sn_s3, sn_q;
  logic [27:0] a0_s1, a0_s2, a0_s3, a1_s1, a1_s2, a1_s3;
  always_ff @(posedge clk_i) begin
    en_s1 <= enable_i;
    en_s2 <= en_s1;
    en_s3 <= en_s2;
    sn_s1 <= sense_i;
    sn_s2 <= sn_s1;
    sn_s3 <= sn_s2;
    a0_s1 <= bus0_addr_i;
    a0_s2 <= a0_s1;
    a1_s1 <= bus1_addr_i;
    a1_s2 <= a1_s1;
    a0_s3 <= a0_s2;
    a1_s3 <= a1_s2;
  end

  // A change counts once the second and third stages agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 2'h0;
      sn_q <= 6'h00;
    end else begin
      en_q <= (en_s2 & en_s3) | (en_q & (en_s2 | en_s3));
      sn_q <= (sn_s2 & sn_s3) | (sn_q & (sn_s2 | sn_s3));
    end
  end

  rdc_pkg::rdc_sense_s sense;
  assign sense = rdc_pkg::rdc_sense_s'(sn_q);

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_ctrl = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `RDC_ADR_CTRL);

  logic [1:0] en_d;
  logic bus_sel;
  logic [27:0] order;
  logic in_service;
  logic diag_en;
  logic fail;
  logic done;
  logic prev_nomove;
  logic [6:0] fault_code;
  logic [CW-1:0] cnt;
  rdc_pkg::rdc_state_e state, next_state;

  // Enable pulse edge on either bus input
  wire [1:0] en_rise = en_q & ~en_d;
  wire start = (en_rise != 2'h0) & in_service & (state == rdc_pkg::RDC_IDLE);
  wire sys_reset = wr_ctrl & wb_dat_i[`RDC_CTRL_SYSRST];

  // Address bits count once two filter stages agree; a glitch on a
  // line mid-window would otherwise be OR-ed into the buffer for good
  wire [27:0] a0_ok = a0_s2 & a0_s3;
  wire [27:0] a1_ok = a1_s2 & a1_s3;
  // Steering: only the selected bus feeds the buffer, so the idle
  // bus may carry anything without disturbing the order
  wire [27:0] steered = bus_sel ? a1_ok : a0_ok;

  rdc_pkg::rdc_order_s ord;
  assign ord = rdc_pkg::rdc_order_s'(order);

  function automatic logic one_hot8(input logic [7:0] v);
    one_hot8 = (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
  endfunction

  // One-hot check of every field; diag order allowed with option
  wire ctype_diag = DIAG_FITTED && diag_en
                    && (ord.cycle_type_select == `RDC_CTYPE_DIAG);
  wire ctype_ok = one_hot8({6'h00, ord.cycle_type_select}) | ctype_diag;
  wire addr_ok = one_hot8(ord.path_group_first)
                 & one_hot8(ord.path_group_second)
                 & one_hot8({4'h0, ord.path_group_fourth})
                 & one_hot8({6'h00, ord.path_group_third})
                 & one_hot8({6'h00, ord.operate_release_select})
                 & one_hot8({6'h00, ord.selector_half_select})
                 & ctype_ok;

  wire is_release = ord.operate_release_select[1];
  wire diag_on = DIAG_FITTED && diag_en;

  // Path and relay checks, valid once the selection is driven
  wire path_bad = ~sense.path_one;
  wire multi_bad = sense.relay_multi;
  wire none_bad = diag_on & sense.relay_none;
  wire stage1_bad = diag_on & sense.stage1_err;
  wire dbl_rel = is_release & sense.double_release;
  wire strobe_open = (cnt >= CW'(STROBE_CYC));
  wire moved = strobe_open & sense.armature_move;

  // Next state
  // Double release is tested before the strobe on purpose: waiting
  // for chatter to settle would leave time for the relay to operate
  always_comb begin
    next_state = state;
    unique case (state)
      rdc_pkg::RDC_IDLE: begin
        if (start) begin
          next_state = rdc_pkg::RDC_WINDOW;
        end
      end
      rdc_pkg::RDC_WINDOW: begin
        if (cnt == CW'(WIN_CYC - 1)) begin
          next_state = rdc_pkg::RDC_CHECK;
        end
      end
      rdc_pkg::RDC_CHECK: begin
        if (!addr_ok) begin
          next_state = rdc_pkg::RDC_FAIL;
        end else begin
          next_state = rdc_pkg::RDC_DRIVE;
        end
      end
      rdc_pkg::RDC_DRIVE: begin
        if (dbl_rel) begin
          next_state = rdc_pkg::RDC_FAIL;
        end else if (strobe_open && (path_bad || multi_bad || none_bad || stage1_bad)) begin
          next_state = rdc_pkg::RDC_FAIL;
        end else if (moved) begin
          next_state = rdc_pkg::RDC_HOLD;
        end else if (cnt == CW'(MOVE_TMO - 1)) begin
          next_state = rdc_pkg::RDC_FAIL;
        end
      end
      rdc_pkg::RDC_HOLD: begin
        if (cnt >= CW'(HOLD_CYC - 1)) begin
          next_state = rdc_pkg::RDC_IDLE;
        end
      end
      rdc_pkg::RDC_FAIL: begin
        next_state = rdc_pkg::RDC_FAIL;
      end
      default: begin
        next_state = rdc_pkg::RDC_FAIL;
      end
    endcase
  end

  // Sequencer with its cycle counter
  // One counter serves window, strobe, timeout and hold; it restarts
  // on every state change, so each phase counts from zero
  always_ff @(posedge clk_i) begin
    if (rst_i || sys_reset) begin
      state <= rdc_pkg::RDC_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= (next_state != state) ? '0 : cnt + CW'(1);
    end
  end

  // Enable register and address buffer
  // The buffer only accumulates during the window; a failed cycle
  // keeps it for inspection until the system reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_d <= 2'h0;
      bus_sel <= 1'b0;
      order <= `RDC_ZERO28;
    end else begin
      en_d <= en_q;
      if (start) begin
        bus_sel <= en_rise[1];
        order <= `RDC_ZERO28;
      end else if (state == rdc_pkg::RDC_WINDOW) begin
        order <= order | steered;
      end else if (sys_reset
                   || (state == rdc_pkg::RDC_HOLD && next_state == rdc_pkg::RDC_IDLE)) begin
        order <= `RDC_ZERO28;
      end
    end
  end

  // Fault bookkeeping; a missed movement stays visible until the system reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail <= 1'b0;
      done <= 1'b0;
      prev_nomove <= 1'b0;
      fault_code <= `RDC_ZERO7;
    end else if (sys_reset) begin
      fail <= 1'b0;
      prev_nomove <= 1'b0;
      fault_code <= `RDC_ZERO7;
    end else begin
      if (start) begin
        done <= 1'b0;
      end
      if (state == rdc_pkg::RDC_HOLD && next_state == rdc_pkg::RDC_IDLE) begin
        done <= 1'b1;
        prev_nomove <= 1'b0;
      end
      if (next_state == rdc_pkg::RDC_FAIL && state != rdc_pkg::RDC_FAIL) begin
        fail <= 1'b1;
        fault_code[`RDC_F_ADDR] <= (state == rdc_pkg::RDC_CHECK);
        fault_code[`RDC_F_PATH] <= (state == rdc_pkg::RDC_DRIVE) & path_bad;
        fault_code[`RDC_F_MULTI] <= (state == rdc_pkg::RDC_DRIVE) & multi_bad;
        fault_code[`RDC_F_NONE] <= (state == rdc_pkg::RDC_DRIVE) & none_bad;
        fault_code[`RDC_F_STAGE1] <= (state == rdc_pkg::RDC_DRIVE) & stage1_bad;
        fault_code[`RDC_F_DBLREL] <= dbl_rel;
        fault_code[`RDC_F_NOMOVE] <= (state == rdc_pkg::RDC_DRIVE) & ~dbl_rel
                                     & (cnt == CW'(MOVE_TMO - 1));
        prev_nomove <= (state == rdc_pkg::RDC_DRIVE) & (cnt == CW'(MOVE_TMO - 1));
      end
    end
  end

  // Control: starts quarantined after power-up
  // Software must set in service before any enable is honoured, so
  // a half-initialised controller never drives the selector
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_service <= 1'b0;
      diag_en <= 1'b0;
    end else if (wr_ctrl) begin
      in_service <= wb_dat_i[`RDC_CTRL_INSVC];
      diag_en <= wb_dat_i[`RDC_CTRL_DIAG];
    end
  end

  // Outputs, all registered
  wire driving = (state == rdc_pkg::RDC_DRIVE) | (state == rdc_pkg::RDC_HOLD);
  // A double release drops the whole path, not just the pulser, so the
  // selector never sits on a relay with no command behind it
  wire drive_ok = driving & ~dbl_rel;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_verify_o <= 1'b0;
      select_o <= `RDC_ZERO28;
      operate_o <= 1'b0;
      release_o <= 1'b0;
      fault_o <= 1'b0;
      quarantine_o <= 1'b1;
    end else begin
      enable_verify_o <= (state == rdc_pkg::RDC_WINDOW)
                         && (cnt == CW'(WIN_CYC - 1));
      select_o <= drive_ok ? order : `RDC_ZERO28;
      operate_o <= drive_ok & ord.operate_release_select[0];
      release_o <= drive_ok & is_release;
      fault_o <= fail | (next_state == rdc_pkg::RDC_FAIL) | prev_nomove;
      quarantine_o <= ~in_service;
    end
  end

  // Read mux
  // Status is read live, not latched, so a poll may see busy one
  // cycle after the sequencer has already moved on
  wire [31:0] stat_word = {27'h0000000,
                           enable_verify_o,
                           done,
                           ~in_service,
                           fail,
                           state != rdc_pkg::RDC_IDLE};
  wire [31:0] rd_mux = (wb_adr_i == `RDC_ADR_CTRL) ? {29'h00000000, in_service, diag_en, 1'b0}
                     : (wb_adr_i == `RDC_ADR_STAT) ? stat_word
                     : (wb_adr_i == `RDC_ADR_ORDER) ? {4'h0, order}
                     : (wb_adr_i == `RDC_ADR_FAULT) ? {25'h0000000, fault_code}
                     : `RDC_ZERO32;

  // Single-cycle ack; unmapped reads return zero
  // Ack masks the request for one cycle so a held strobe is not
  // taken twice; the master must drop stb between transfers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= `RDC_ZERO32;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : `RDC_ZERO32;
    end
  end

endmodule

//--- verif/rdc_monitor.sv
/*
  Port checker of the relay distributor controller.
  Assumes a bind onto rdc_top that hands on its timing parameters.
*/
`timescale 1ns/100ps
module rdc_monitor #(
  parameter int WIN_CYC = 4,
  parameter int STROBE_CYC = 2,
  parameter int HOLD_CYC = 3,
  parameter int MOVE_TMO = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_ack_o,
  input wire logic enable_verify_o,
  input wire logic [27:0] select_o,
  input wire logic operate_o,
  input wire logic release_o,
  input wire logic fault_o,
  input wire logic quarantine_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Driven order split into fields
  wire rdc_pkg::rdc_order_s ord = select_o;
  wire sel_on = |select_o;
  wire fields_ok = $onehot(ord.path_group_first) && $onehot(ord.path_group_second)
    && $onehot(ord.path_group_fourth) && $onehot(ord.path_group_third)
    && $onehot(ord.operate_release_select) && $onehot(ord.selector_half_select)
    && ($onehot(ord.cycle_type_select) || ord.cycle_type_select == 2'h3);

  // Drive length; a drive cut short must be a fault, never a success
  logic [15:0] cnt;
  always_ff @(posedge clk_i) begin
    cnt <= (rst_i || !sel_on) ? 16'h0000 : cnt + 16'h0001;
  end

  sequence s_short_end;
    $fell(sel_on) && cnt < STROBE_CYC + HOLD_CYC;
  endsequence
  sequence s_verify_end;
    enable_verify_o ##1 !enable_verify_o;
  endsequence

  chk_verify_pulse: assert property (enable_verify_o |-> s_verify_end)
    else $error("verify pulse longer than one cycle");
  chk_fields_onehot: assert property (sel_on |-> fields_ok)
    else $error("order driven with a bad field");
  chk_op_rel_field: assert property (sel_on |-> operate_o == ord.operate_release_select[0]
    && release_o == ord.operate_release_select[1])
    else $error("pulser does not follow order field");
  chk_order_held: assert property (sel_on && $past(sel_on) |-> $stable(select_o))
    else $error("order changed during drive");
  chk_short_drive: assert property (s_short_end |-> ##[0:2] fault_o)
    else $error("cycle ended before strobe and hold time");
  chk_fault_no_drive: assert property (fault_o && $past(fault_o) |-> !sel_on
    && !operate_o && !release_o)
    else $error("drive continues after fault");
  chk_quar_idle: assert property (quarantine_o |-> !sel_on && !enable_verify_o)
    else $error("activity while quarantined");
  chk_fault_sticky: assert property ($fell(fault_o) |-> $past(wb_ack_o)
    || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("fault cleared without bus reset");
endmodule

//--- verif/rdc_cpu_model.sv
/*
  Processor side model: raises one enable and puts an order on its bus.
  Assumes start_i pulses one cycle with order, bus and pace set.
*/
`timescale 1ns/100ps
module rdc_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic bus_i,
  input wire logic slow_i,
  input wire logic [27:0] order_i,
  input wire logic verify_i,
  output logic [1:0] enable_o,
  output logic [27:0] bus0_o,
  output logic [27:0] bus1_o,
  output logic seen_o
);
  logic act;
  logic sel;
  logic [3:0] dly;

  // Unused and released lines toggle so stale values never look valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act <= 1'h0;
      sel <= 1'h0;
      dly <= 4'h0;
      seen_o <= 1'h0;
      enable_o <= 2'h0;
      bus0_o <= 28'hFFFFFFF;
      bus1_o <= 28'h0000000;
    end else if (start_i) begin
      act <= 1'h1;
      sel <= bus_i;
      seen_o <= 1'h0;
      enable_o <= 2'h0;
      dly <= slow_i ? 4'h8 : 4'h4; // Low long enough to pass the filter
      bus0_o <= bus_i ? ~bus0_o : order_i;
      bus1_o <= bus_i ? order_i : ~bus1_o;
    end else if (act) begin
      dly <= (dly != 4'h0) ? dly - 4'h1 : dly;
      enable_o <= (dly == 4'h1) ? (sel ? 2'h2 : 2'h1) : enable_o;
      if (verify_i) begin
        act <= 1'h0;
        seen_o <= 1'h1;
        enable_o <= 2'h0;
        bus0_o <= ~bus0_o;
        bus1_o <= ~bus1_o;
      end else if (sel) begin
        bus0_o <= ~bus0_o;
      end else begin
        bus1_o <= ~bus1_o;
      end
    end
  end
endmodule

//--- verif/rdc_top_tb_top.sv
/*
  Bench top of the relay distributor controller: bus tasks and order table.
  Assumes the package, checker and processor model are compiled first.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("unexpected at %0t: got %h want %h", $time, (a), (e)); end end
module rdc_top_tb_top;
  logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic start = 1'h0, bus = 1'h0, slow = 1'h0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] dat = 32'h0, rd, dat_o;
  logic [5:0] sense = 6'h00;
  logic [27:0] order = 28'h0, last_sel = 28'h0, bus0, bus1, sel_o;
  logic [1:0] enable;
  logic ack, verify, oper, rel, fault, quar, seen;
  int n_errors = 0, checks = 0;
  // Good operate, release, diag; bad field; then one sense fault each
  logic [27:0] ords [10] = '{28'h5540201, 28'h5940201, 28'hD540201, 28'h5540203,
    28'h5540201, 28'h5540201, 28'h5540201, 28'h5540201, 28'h5540201, 28'h5940201};
  logic [5:0] sns [10] = '{6'h22, 6'h22, 6'h22, 6'h22, 6'h30, 6'h28, 6'h24, 6'h02,
    6'h20, 6'h21};
  logic [6:0] flts [10] = '{7'h00, 7'h00, 7'h00, 7'h01, 7'h04, 7'h08, 7'h10, 7'h02,
    7'h20, 7'h40};

  rdc_top #(.WIN_CYC(4), .STROBE_CYC(2), .HOLD_CYC(3), .MOVE_TMO(20)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .enable_i(enable), .bus0_addr_i(bus0), .bus1_addr_i(bus1), .sense_i(sense),
    .enable_verify_o(verify), .select_o(sel_o), .operate_o(oper), .release_o(rel),
    .fault_o(fault), .quarantine_o(quar));
  rdc_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .bus_i(bus),
    .slow_i(slow), .order_i(order), .verify_i(verify), .enable_o(enable),
    .bus0_o(bus0), .bus1_o(bus1), .seen_o(seen));

  initial forever #12.5 clk_i = ~clk_i;
  // Last order seen on the selector
  always @(posedge clk_i) if (sel_o != 28'h0) last_sel <= sel_o;

  task automatic wrap_up;
    if (n_errors == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Classic single cycle; entered just after a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do begin @(posedge clk_i); n++; end while (ack !== 1'h1 && n < 20);
    rd = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
    @(posedge clk_i);
    if (n >= 20) begin n_errors++; wrap_up(); end
  endtask

  // One order from the table, then its outcome over the bus
  task automatic run(input int i);
    int n;
    n = 0;
    sense <= sns[i];
    order <= ords[i];
    bus <= i[0];
    slow <= i[1];
    start <= 1'h1;
    @(posedge clk_i);
    start <= 1'h0;
    do begin @(posedge clk_i); n++; end while (seen !== 1'h1 && n < 60);
    `CHK(seen, 1'h1)
    do begin wb(1'h0, 4'h4, 32'h0); n++; end while (rd[1:0] === 2'h1 && n < 120);
    if (n >= 120) begin n_errors++; wrap_up(); end
    `CHK(rd[1], flts[i] != 7'h00)
    wb(1'h0, 4'hC, 32'h0);
    `CHK(rd[6:0], flts[i])
    if (flts[i] == 7'h00) begin
      `CHK(last_sel, ords[i])
      wb(1'h0, 4'h4, 32'h0);
      `CHK(rd[3], 1'h1)
      wb(1'h0, 4'h8, 32'h0);
      `CHK(rd[27:0], 28'h0)
    end else begin
      wb(1'h1, 4'h0, 32'h7);
      repeat (3) @(posedge clk_i);
      `CHK(fault, 1'h0)
    end
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    `CHK(quar, 1'h1)
    wb(1'h0, 4'h4, 32'h0);
    `CHK(rd[2], 1'h1)
    order <= 28'h5540201;
    start <= 1'h1;
    @(posedge clk_i);
    start <= 1'h0;
    repeat (30) @(posedge clk_i);
    `CHK(seen, 1'h0)
    wb(1'h1, 4'h0, 32'h6);
    wb(1'h0, 4'h4, 32'h0);
    `CHK(rd[2], 1'h0)
    wb(1'h0, 4'h1, 32'h0);
    `CHK(rd, 32'h0)
    for (int i = 0; i < 10; i++) run(i);
    wrap_up();
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
endmodule

bind rdc_top rdc_monitor #(.WIN_CYC(WIN_CYC), .STROBE_CYC(STROBE_CYC),
  .HOLD_CYC(HOLD_CYC), .MOVE_TMO(MOVE_TMO)) mon (.clk_i(clk_i), .rst_i(rst_i),
  .wb_ack_o(wb_ack_o), .enable_verify_o(enable_verify_o), .select_o(select_o),
  .operate_o(operate_o), .release_o(release_o), .fault_o(fault_o),
  .quarantine_o(quarantine_o));
